// ---- rtl/ees_sequencer.sv ----
// two-wire serial memory slave: bus sequencer, page latches, array and write fifo
//
// Overview of operation
// - ack select only when type and the straps not used as address bits match, else standby
// - only stop in tenth slot starts write
// - select and address acked even when protected
// - protected byte write: data nacked, unchanged
// - unprotected byte write: data byte acknowledged
// - page write stores sixteen bytes in one cycle
// - one to sixteen data bytes, each acked
// - protected page write: all data nacked, unchanged
// - page write advances only low four bits
// - write cycle releases bus, ignores all activity
// - polling nacked while busy, acked after
// - reads ignore the write-protect level
// - address counter advances per byte read
// - random read: dummy write, restart, read
// - current read outputs counter byte, then increments
// - acked read byte streams next address
// - counter wraps past top to zero
// - ninth bit high ends read, standby
// - array starts with every byte all ones
`include "ees_regs.svh"

// =====================================================================
// write-data fifo
module ees_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = `EES_FIFO_DEPTH  // power of two: pointers wrap freely
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;  // next slot to fill
    logic [PW-1:0] rd_ptr;  // oldest entry
    logic [PW:0]   count;   // entries held
  } ees_fifo_s;

  ees_fifo_s        q;                // registered state
  ees_fifo_s        d;                // next state
  logic [WIDTH-1:0] slot_q [DEPTH];   // storage, not reset
  logic             push;             // accepted write
  logic             pop;              // accepted read

  assign in_ready_out  = (q.count != FULL);
  assign out_valid_out = (q.count != '0);
  assign out_data_out  = slot_q[q.rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // pointer and count update
  always_comb begin
    d = q;
    if (push) begin
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
    d.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage write
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      slot_q[q.wr_ptr] <= in_data_in;
    end
  end
endmodule : ees_fifo

// =====================================================================
// bus sequencer top
module ees_sequencer #(
  parameter int         ADDR_W       = `EES_ADDR_W,        // 8..11
  parameter logic [3:0] DEV_TYPE     = 4'h5,               // arbitrary type code
  parameter int         WRITE_CYCLES = `EES_WRITE_CYCLES,
  parameter int         FIFO_DEPTH   = `EES_FIFO_DEPTH
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic write_protect_input_in,
  input  wire logic chip_strap_bit0_in,
  input  wire logic chip_strap_bit1_in,
  input  wire logic chip_strap_bit2_in,
  output logic      busy_out
);
  localparam int UP   = ADDR_W - 8;                // address bits carried by the select
  localparam int WT_W = $clog2(WRITE_CYCLES + 1);  // write timer width
  localparam int PB   = `EES_PAGE_BITS;
  localparam int NP   = `EES_PAGE_BYTES;

  // =====================================================================
  // state
  typedef struct packed {
    ees_pkg::ees_state_e state;       // sequencer state
    logic [2:0]          scl_sync;    // [0] first flop, [1] second, [2] previous
    logic [2:0]          sda_sync;    // same layout as scl
    logic [1:0]          wp_sync;     // write-protect synchroniser
    logic [5:0]          strap_sync;  // [2:0] first flops, [5:3] second
    logic [3:0]          bit_cnt;     // rising edges of the current byte
    logic [7:0]          shift;       // byte in or out
    logic [ADDR_W-1:0]   addr;        // internal address counter
    logic                wp_seen;     // protect seen since start
    logic                sda_oe;      // pulls the data line low
    logic                sda_low;     // open-drain level, always low
    logic                busy;        // write cycle running
    logic [WT_W-1:0]     timer;       // write cycle countdown
    logic                commit;      // one cycle: copy latches to array
  } ees_core_s;

  ees_core_s      q;                    // registered state
  ees_core_s      d;                    // next state
  logic [7:0]     mem_q [2**ADDR_W] = '{default: `EES_MEM_INIT};  // erased array
  logic [7:0]     latch_q [NP];         // page latches
  logic [NP-1:0]  latch_vld_q;          // latches holding data
  logic           scl;                  // synchronised clock level
  logic           sda;                  // synchronised data level
  logic           rise;                 // clock rising
  logic           fall;                 // clock falling
  logic           start_ev;             // start seen
  logic           stop_ev;              // stop seen
  logic           sel_ok;               // select byte addresses this device
  logic           page_any;             // page data pending
  logic           push;                 // data byte into fifo
  logic           page_clear;           // new address: drop old latches
  logic           load_rd;              // fetch next read byte
  logic           f_ready;              // fifo can take a byte
  logic           f_valid;              // fifo holds a byte
  logic [PB+7:0]  f_data;               // fifo head: page offset and data
  logic           drain;                // fifo into latches

  // open-drain select match; straps under address bits are not compared
  function automatic logic sel_match(input logic [7:0] sel, input logic [2:0] strap);
    logic ok;
    ok = (sel[`EES_SEL_TYPE_MSB:`EES_SEL_TYPE_LSB] == DEV_TYPE);
    for (int i = 0; i < 3; i++) begin
      if (i >= UP && sel[i+`EES_SEL_STRAP_LSB] != strap[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : sel_match

  // edge and condition detection on the second synchroniser flops only
  assign scl      = q.scl_sync[1];
  assign sda      = q.sda_sync[1];
  assign rise     = scl && !q.scl_sync[2];
  assign fall     = !scl && q.scl_sync[2];
  assign start_ev = scl && q.scl_sync[2] && q.sda_sync[2] && !sda;
  assign stop_ev  = scl && q.scl_sync[2] && !q.sda_sync[2] && sda;
  assign sel_ok   = sel_match(q.shift, q.strap_sync[5:3]);
  assign page_any = (latch_vld_q != '0) || f_valid;
  assign drain    = (q.state != ees_pkg::EES_WCYCLE);  // latches frozen while copying

  // =====================================================================
  // sequencer next state
  always_comb begin
    d          = q;
    push       = 1'b0;
    page_clear = 1'b0;
    load_rd    = 1'b0;
    d.scl_sync   = {q.scl_sync[1:0], scl_in};
    d.sda_sync   = {q.sda_sync[1:0], sda_in};
    d.wp_sync    = {q.wp_sync[0], write_protect_input_in};
    d.strap_sync = {q.strap_sync[2:0], chip_strap_bit2_in, chip_strap_bit1_in,
                    chip_strap_bit0_in};
    d.commit     = 1'b0;
    if (q.state == ees_pkg::EES_WCYCLE) begin
      // the bus is not even watched here, so polls go unanswered
      if (q.timer <= WT_W'(1)) begin
        d.commit = 1'b1;
        d.busy   = 1'b0;
        d.state  = ees_pkg::EES_IDLE;
      end else begin
        d.timer = q.timer - 1'b1;
      end
    end else if (start_ev) begin
      // start or repeated start: counter kept for random read
      d.state   = ees_pkg::EES_SEL;
      d.bit_cnt = '0;
      d.sda_oe  = 1'b0;
      d.wp_seen = q.wp_sync[1];
    end else if (stop_ev) begin
      d.sda_oe = 1'b0;
      // only a stop in the slot after a data ack writes
      if (q.state == ees_pkg::EES_WDATA && q.bit_cnt == 4'h1 && page_any && !q.wp_seen) begin
        d.state = ees_pkg::EES_WCYCLE;
        d.busy  = 1'b1;
        d.timer = WT_W'(WRITE_CYCLES);
      end else begin
        d.state = ees_pkg::EES_IDLE;
      end
    end else begin
      // protect is sampled from start to the end of the address byte
      if (q.state == ees_pkg::EES_SEL || q.state == ees_pkg::EES_SEL_ACK ||
          q.state == ees_pkg::EES_ADDR) begin
        d.wp_seen = q.wp_seen || q.wp_sync[1];
      end
      unique case (q.state)
        ees_pkg::EES_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ees_pkg::EES_SEL, ees_pkg::EES_ADDR, ees_pkg::EES_WDATA: begin
          if (rise && q.bit_cnt < 4'h8) begin
            d.shift   = {q.shift[6:0], sda};
            d.bit_cnt = q.bit_cnt + 1'b1;
          end else if (fall && q.bit_cnt == 4'h8) begin
            if (q.state == ees_pkg::EES_SEL) begin
              if (sel_ok) begin
                d.sda_oe = 1'b1;
                d.state  = ees_pkg::EES_SEL_ACK;
                for (int i = 0; i < UP; i++) begin
                  d.addr[8+i] = q.shift[i+`EES_SEL_STRAP_LSB];
                end
              end else begin
                d.state = ees_pkg::EES_IDLE;
              end
            end else if (q.state == ees_pkg::EES_ADDR) begin
              d.addr[7:0] = q.shift;
              d.sda_oe    = 1'b1;
              page_clear  = 1'b1;
              d.state     = ees_pkg::EES_ADDR_ACK;
            end else begin
              // full fifo is refused like protection rather than lost
              if (!q.wp_seen && f_ready) begin
                push     = 1'b1;
                d.sda_oe = 1'b1;
                d.addr[PB-1:0] = q.addr[PB-1:0] + 1'b1;
              end else begin
                d.sda_oe = 1'b0;
              end
              d.state = ees_pkg::EES_WDATA_ACK;
            end
          end
        end
        ees_pkg::EES_SEL_ACK: begin
          if (fall) begin
            d.bit_cnt = '0;
            if (q.shift[`EES_SEL_RW_BIT]) begin
              load_rd = 1'b1;
            end else begin
              d.sda_oe = 1'b0;
              d.state  = ees_pkg::EES_ADDR;
            end
          end
        end
        ees_pkg::EES_ADDR_ACK, ees_pkg::EES_WDATA_ACK: begin
          if (fall) begin
            d.sda_oe  = 1'b0;
            d.bit_cnt = '0;
            d.state   = ees_pkg::EES_WDATA;
          end
        end
        ees_pkg::EES_RDATA: begin
          if (rise) begin
            d.bit_cnt = q.bit_cnt + 1'b1;
          end else if (fall && q.bit_cnt == 4'h8) begin
            d.sda_oe  = 1'b0;  // release for the master ack
            d.bit_cnt = '0;
            d.state   = ees_pkg::EES_RACK;
          end else if (fall && q.bit_cnt != 4'h0) begin
            d.shift  = {q.shift[6:0], 1'b0};
            d.sda_oe = !q.shift[6];
          end
        end
        ees_pkg::EES_RACK: begin
          if (rise) begin
            if (sda) begin
              d.state = ees_pkg::EES_IDLE;
            end else begin
              d.bit_cnt = 4'h9;  // acked: stream on
            end
          end else if (fall && q.bit_cnt == 4'h9) begin
            d.bit_cnt = '0;
            load_rd   = 1'b1;
          end
        end
        ees_pkg::EES_WCYCLE: begin
          d.state = ees_pkg::EES_WCYCLE;
        end
      endcase
      // fetch a byte, drive its first bit, advance the counter with wrap
      if (load_rd) begin
        d.shift  = mem_q[q.addr];
        d.sda_oe = !mem_q[q.addr][7];
        d.addr   = q.addr + 1'b1;
        d.state  = ees_pkg::EES_RDATA;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q <= '{state: ees_pkg::EES_IDLE, scl_sync: 3'h7, sda_sync: 3'h7, default: '0};
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // write data path: fifo, page latches, array
  ees_fifo #(
    .WIDTH (PB + 8),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .in_valid_in   (push),
    .in_ready_out  (f_ready),
    .in_data_in    ({q.addr[PB-1:0], q.shift}),
    .out_valid_out (f_valid),
    .out_ready_in  (drain),
    .out_data_out  (f_data)
  );

  // latches; an overrun simply lands on an earlier offset of the page
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || page_clear || q.commit) begin
      latch_vld_q <= '0;
    end else if (f_valid && drain) begin
      latch_vld_q[f_data[PB+7:8]] <= 1'b1;
    end
    if (f_valid && drain) begin
      latch_q[f_data[PB+7:8]] <= f_data[7:0];
    end
  end

  // one commit copies every latched byte of the page; the array itself is never reset
  always_ff @(posedge clk_sys_in) begin
    if (q.commit) begin
      for (int i = 0; i < NP; i++) begin
        if (latch_vld_q[i]) begin
          mem_q[{q.addr[ADDR_W-1:PB], PB'(i)}] <= latch_q[i];
        end
      end
    end
  end

  assign sda_out    = q.sda_low;
  assign sda_oe_out = q.sda_oe;
  assign busy_out   = q.busy;

  // =====================================================================
  // assertions
  default clocking ck @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_sel_mismatch: assert property ((q.state == ees_pkg::EES_SEL) && fall &&
      q.bit_cnt == 4'h8 && !sel_ok |=> !q.sda_oe && q.state == ees_pkg::EES_IDLE)
    else $error("select mismatch was acknowledged");
  a_stop_slot: assert property (stop_ev && !(q.state == ees_pkg::EES_WDATA &&
      q.bit_cnt == 4'h1) && q.state != ees_pkg::EES_WCYCLE |=> !q.busy)
    else $error("stop outside the tenth slot started a write");
  a_addr_ack: assert property ((q.state == ees_pkg::EES_ADDR) && fall &&
      q.bit_cnt == 4'h8 && !start_ev && !stop_ev |=> q.sda_oe ##1 q.sda_oe)
    else $error("address byte not acknowledged");
  a_protect_nack: assert property ((q.state == ees_pkg::EES_WDATA) && fall &&
      q.bit_cnt == 4'h8 && q.wp_seen |=> !q.sda_oe && $stable(latch_vld_q))
    else $error("protected data byte acknowledged");
  a_data_ack: assert property ((q.state == ees_pkg::EES_WDATA) && fall &&
      q.bit_cnt == 4'h8 && !q.wp_seen && f_ready |=> q.sda_oe)
    else $error("unprotected data byte not acknowledged");
  a_page_incr: assert property (push |=>
      q.addr[ADDR_W-1:PB] == $past(q.addr[ADDR_W-1:PB]) &&
      q.addr[PB-1:0] == PB'($past(q.addr[PB-1:0]) + 1'b1))
    else $error("page write address moved outside its page");
  a_busy_quiet: assert property (q.state == ees_pkg::EES_WCYCLE |->
      !q.sda_oe && q.busy ##1 !q.sda_oe)
    else $error("bus driven during the write cycle");
  a_write_len: assert property ($rose(q.busy) |-> q.busy [*8])
    else $error("write cycle ended too soon");
  a_read_incr: assert property (load_rd && !start_ev && !stop_ev |=>
      q.addr == ADDR_W'($past(q.addr) + 1'b1) && q.state == ees_pkg::EES_RDATA)
    else $error("read counter did not advance");
  a_read_nack: assert property ((q.state == ees_pkg::EES_RACK) && rise && sda &&
      !start_ev && !stop_ev |=> q.state == ees_pkg::EES_IDLE ##1 !q.sda_oe)
    else $error("read went on after a master nack");

  c_page_commit: cover property (q.commit && latch_vld_q == '1);
  c_seq_read: cover property ((q.state == ees_pkg::EES_RACK) && q.bit_cnt == 4'h9);
  c_poll_busy: cover property (q.busy && start_ev);
  c_protected: cover property (push == 1'b0 && q.wp_seen && q.state == ees_pkg::EES_WDATA_ACK);
endmodule : ees_sequencer

// ---- rtl/ees_regs.svh ----
// constants of the two-wire serial memory slave: field positions, reset values, timing
`ifndef EES_REGS_SVH
`define EES_REGS_SVH

// =====================================================================
// select byte layout
`define EES_SEL_RW_BIT      0
`define EES_SEL_TYPE_MSB    7
`define EES_SEL_TYPE_LSB    4
`define EES_SEL_STRAP_LSB   1

// =====================================================================
// array geometry and reset values
`define EES_ADDR_W          11
`define EES_PAGE_BITS       4
`define EES_PAGE_BYTES      16
`define EES_MEM_INIT        8'hff
`define EES_FIFO_DEPTH      8

// =====================================================================
// timing
`define EES_CLK_PERIOD_NS   5
`define EES_WRITE_TIME_NS   5000
`define EES_WRITE_CYCLES    ((`EES_WRITE_TIME_NS + `EES_CLK_PERIOD_NS - 1) / `EES_CLK_PERIOD_NS)

`endif

// ---- rtl/ees_pkg.sv ----
// types shared by the two-wire serial memory slave
package ees_pkg;

  // =====================================================================
  // bus sequencer states, one-hot
  typedef enum logic [9:0] {
    EES_IDLE      = 10'h001,  // standby, waits for a start
    EES_SEL       = 10'h002,  // shifting in the select byte
    EES_SEL_ACK   = 10'h004,  // ninth clock of the select byte
    EES_ADDR      = 10'h008,  // shifting in the address byte
    EES_ADDR_ACK  = 10'h010,  // ninth clock of the address byte
    EES_WDATA     = 10'h020,  // shifting in a data byte
    EES_WDATA_ACK = 10'h040,  // ninth clock of a data byte
    EES_RDATA     = 10'h080,  // shifting out a read byte
    EES_RACK      = 10'h100,  // master acknowledge slot of a read byte
    EES_WCYCLE    = 10'h200   // internal write cycle, bus ignored
  } ees_state_e;

endpackage : ees_pkg

// ---- test/ees_bus_master.sv ----
// bus master model: drives the serial clock and pulls the shared data line
module ees_bus_master (
  output logic      scl_out,   // serial clock, parked high between frames
  output logic      pull_out,  // high while the master pulls data low
  input  wire logic sda_in     // resolved data line level
);
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // idle bus: clock stands still high, data released to the pull-up
  initial begin
    scl_out  = 1'b1;
    pull_out = 1'b0;
  end

  // =====================================================================
  // one 48 ns bit slot; data moves mid-low so both synced lines keep their order
  task automatic bit_slot(input logic b, output logic r);
    #12 pull_out = !b;
    #12 scl_out = 1'b1;
    #22 r = sda_in;  // late in the high phase: slave output has long settled
    #2 scl_out = 1'b0;
  endtask : bit_slot

  // start or repeated start; release first, with margin, so no stop is seen
  task automatic start;
    #12 pull_out = 1'b0;
    #24 scl_out = 1'b1;
    #24 pull_out = 1'b1;
    #24 scl_out = 1'b0;
  endtask : start

  // stop; its clock rise is the slot right after the last ack
  task automatic stop;
    #12 pull_out = 1'b1;
    #12 scl_out = 1'b1;
    #24 pull_out = 1'b0;
    #24;
  endtask : stop

  // eight bits msb first, then the ninth slot with the given level
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
                      output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], q[i]);
    end
    bit_slot(b9, r9);  // master ack low keeps a read going, high ends it
  endtask : xfer
endmodule : ees_bus_master

// ---- test/ees_testbench.sv ----
// self-checking bench of the serial memory sequencer with a bus master model
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // settings and signals
  localparam int         WCYC  = 20;      // short write cycle keeps the run brief
  localparam logic [3:0] DT    = 4'h5;    // arbitrary type code
  localparam logic [2:0] STRAP = 3'b101;  // strap levels, all compared at 8 address bits
  logic       clk_sys;
  logic       reset;
  logic       scl;
  logic       mst_pull;
  wire logic  sda;
  logic       sda_o;
  logic       sda_oe;
  logic       wp;
  logic [2:0] strap;
  logic       busy;
  int         num_errors;
  int         total_checks;
  int         cyc;
  int         busy_cnt;

  // open-drain wire with pull-up: low when either party pulls
  assign sda = (sda_oe ? sda_o : 1'b1) && !mst_pull;

  ees_sequencer #(.ADDR_W(8), .DEV_TYPE(DT), .WRITE_CYCLES(WCYC), .FIFO_DEPTH(8)) u_dut (
    .clk_sys_in(clk_sys), .reset_in(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .write_protect_input_in(wp), .chip_strap_bit0_in(strap[0]),
    .chip_strap_bit1_in(strap[1]), .chip_strap_bit2_in(strap[2]), .busy_out(busy));

  ees_bus_master u_mst (.scl_out(scl), .pull_out(mst_pull), .sda_in(sda));

  // =====================================================================
  // clock, busy length counter and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (busy === 1'b1) begin
      busy_cnt++;
    end
    if (cyc == 20000) begin  // more than twice the roughly eight thousand cycles the tests need
      num_errors++;
      stop_test();
    end
  end

  // =====================================================================
  // access tasks
  function automatic logic [7:0] sel(input logic rw);
    return {DT, STRAP, rw};
  endfunction : sel

  // one written byte and the device's answer in slot nine
  task automatic send(input logic [7:0] d, input logic ack_exp);
    logic [7:0] q;
    logic       r;
    u_mst.xfer(d, 1'b1, q, r);
    `CHECK(!r, ack_exp)
  endtask : send

  // one read byte; last leaves it unacknowledged
  task automatic recv(input logic [7:0] exp, input logic last);
    logic [7:0] q;
    logic       r;
    u_mst.xfer(8'hff, last, q, r);
    `CHECK(q, exp)
  endtask : recv

  // dummy write of the address, restart with the same select bits, read select
  task automatic seek(input logic [7:0] a);
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(a, 1'b1);
    u_mst.start();
    send(sel(1'b1), 1'b1);
  endtask : seek

  // stop in slot ten, then poll: the first start falls inside the busy window
  task automatic wr_end;
    logic [7:0] q;
    logic       r;
    int         n;
    busy_cnt = 0;
    u_mst.stop();
    `CHECK(busy, 1'b1)
    n = 0;
    r = 1'b1;
    while (r && n < 8) begin
      u_mst.start();
      u_mst.xfer(sel(1'b0), 1'b1, q, r);
      n++;
    end
    u_mst.stop();
    `CHECK(n > 1, 1'b1)
    `CHECK(r, 1'b0)
    `CHECK(busy_cnt, WCYC)
  endtask : wr_end

  // a stop that must start nothing
  task automatic no_wr;
    busy_cnt = 0;
    u_mst.stop();
    repeat (40) @(negedge clk_sys);
    `CHECK(busy_cnt, 0)
  endtask : no_wr

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // =====================================================================
  // main sequence
  initial begin
    logic r;
    reset = 1'b1;
    wp = 1'b0;
    strap = STRAP;
    num_errors = 0;
    total_checks = 0;
    cyc = 0;
    busy_cnt = 0;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    `CHECK(sda_oe, 1'b0)
    `CHECK(busy, 1'b0)
    `CHECK(sda_o, 1'b0)
    repeat (4) @(negedge clk_sys);
    // erased array reads all ones
    seek(8'h40);
    recv(8'hff, 1'b1);
    u_mst.stop();
    // byte write at the bottom address
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h3c, 1'b1);
    wr_end();
    // page write that overruns on purpose: third byte folds back into the page
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(8'hfe, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    wr_end();
    // sequential read over the top of the array
    seek(8'hfe);
    recv(8'h11, 1'b0);
    recv(8'h22, 1'b0);
    recv(8'h3c, 1'b1);
    u_mst.stop();
    // current address read continues at the counter
    u_mst.start();
    send(sel(1'b1), 1'b1);
    recv(8'hff, 1'b1);
    u_mst.stop();
    seek(8'hf0);
    recv(8'h33, 1'b0);
    recv(8'hff, 1'b1);
    u_mst.stop();
    // full page of sixteen bytes in one write cycle, read back as a stream
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(8'h20, 1'b1);
    for (int i = 0; i < 16; i++) begin
      send(8'ha0 + 8'(i), 1'b1);
    end
    wr_end();
    seek(8'h20);
    for (int i = 0; i < 16; i++) begin
      recv(8'ha0 + 8'(i), (i == 15));
    end
    u_mst.stop();
    // protect high from start to the address byte, low during data
    @(negedge clk_sys) wp = 1'b1;
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(8'h00, 1'b1);
    @(negedge clk_sys) wp = 1'b0;
    send(8'h55, 1'b0);
    send(8'h66, 1'b0);
    no_wr();
    // stop two slots late after an accepted byte
    u_mst.start();
    send(sel(1'b0), 1'b1);
    send(8'h00, 1'b1);
    send(8'h77, 1'b1);
    u_mst.bit_slot(1'b0, r);
    u_mst.bit_slot(1'b0, r);
    no_wr();
    // reads behave alike with protect high; location kept its value
    @(negedge clk_sys) wp = 1'b1;
    seek(8'h00);
    recv(8'h3c, 1'b1);
    u_mst.stop();
    @(negedge clk_sys) wp = 1'b0;
    // strap mismatch: no ack, then a matching select still works
    u_mst.start();
    send({DT, ~STRAP, 1'b0}, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(sel(1'b1), 1'b1);
    recv(8'hff, 1'b1);
    u_mst.stop();
    stop_test();
  end
endmodule : testbench
